// >>> src/edc_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the device control register bank. Definitions only.
`ifndef EDC_REGS_VH
`define EDC_REGS_VH

`define EDC_OFF_CTRL        20'h00000
`define EDC_OFF_CTRL_ALIAS  20'h00004
`define EDC_OFF_AUX         20'h00008

`define EDC_BIT_FD          0
`define EDC_BIT_BMB         2
`define EDC_BIT_RSV3        3
`define EDC_BIT_AUTO_SPEED_DETECT_EN        5
`define EDC_BIT_SLU         6
`define EDC_BIT_SPD_LO      8
`define EDC_BIT_SPD_HI      9
`define EDC_BIT_FORCE_SPEED_EN      11
`define EDC_BIT_FRCDPX      12
`define EDC_BIT_ADV         20
`define EDC_BIT_MRST        26
`define EDC_BIT_RXP         27
`define EDC_BIT_TXP         28
`define EDC_BIT_VLAN        30
`define EDC_BIT_PHYRST      31

// Writable bits of the control word
`define EDC_WR_MASK         32'hd810_1b7d

`define EDC_SPD_10          2'h0
`define EDC_SPD_100         2'h1
`define EDC_SPD_1000        2'h2
`define EDC_SPD_RESET       2'h2

// Aux status word: bit0 bus_master_idle_status, bit1 reset busy,
// bits 3:2 effective speed, bit4 effective duplex, bit5 link up
`define EDC_AUX_IDLE        0
`define EDC_AUX_BUSY        1

// MAC reset sequence length, 1 us at 100 ns per cycle
`define EDC_MRST_TIME_NS    1000
`define EDC_CLK_PERIOD_NS   100
`define EDC_MRST_CYCLES     (`EDC_MRST_TIME_NS / `EDC_CLK_PERIOD_NS)

`endif

// >>> src/edc_sync3.v
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
module edc_sync3 (
   input  wire clk_i,     // Device clock
   input  wire arst_n_i,  // Async reset, active low
   input  wire d_i,       // Asynchronous input
   output wire q_o        // Filtered synchronous level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg out_q;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         out_q <= 1'b0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end

   assign q_o = out_q;
endmodule

// >>> src/edc_ctrl.v
// Device control register bank of a gigabit Ethernet MAC.
// Assumes a plain register port on clk_i; PHY link, PHY duplex and aux power levels are async.
`timescale 1ns/1ps
`include "edc_regs.vh"

// What this block and its software do
// [RQ1] Control word at primary and alias offsets
// [RQ2] Bit 0 selects half or full duplex
// [RQ3] Master block stops requests, then idle status
// [RQ4] Software writes reserved bits as documented
// [RQ5] Auto-speed bit makes MAC detect speed
// [RQ6] Link and data only while permit set
// [RQ7] Permit resets zero, one with wake mgmt
// [RQ8] Speed field resets 10b, 00/01/10 encoding
// [RQ9] Speed field ignored under auto-speed
// [RQ10] Force speed uses field; bypass wins
// [RQ11] Software keeps PHY speed consistent
// [RQ12] Force duplex uses bit 0, else sampled
// [RQ13] Cold wake advertised only with aux power
// [RQ14] Software keeps cold wake bit set
// [RQ15] MAC reset bit self-clears, reads one while sequence runs
// [RQ16] Rx pause enable, loaded by negotiation
// [RQ17] Tx pause enable, loaded by negotiation
// [RQ18] VLAN mode inserts tags on flagged packets
// [RQ19] VLAN mode strips tags on receive
// [RQ20] Bit 31 holds internal PHY in reset
// [RQ21] Software waits before polling after reset
// [RQ22] MAC reset restores config defaults except PHY reset bit
// [RQ23] Duplex, permit, force speed from NVM
// [RQ24] Reset bit clears when sequence finishes
module edc_ctrl (
   input  wire        clk_i,              // Device clock, 10 MHz
   input  wire        arst_n_i,           // Async reset, active low
   input  wire [19:0] reg_addr_i,         // Register byte address
   input  wire [31:0] reg_wdata_i,        // Write data
   input  wire        reg_wr_i,           // Write strobe
   input  wire        reg_rd_i,           // Read strobe
   output reg  [31:0] reg_rdata_o,        // Read data, cycle after strobe
   input  wire        nvm_valid_i,        // NVM defaults valid pulse
   input  wire        nvm_fd_i,           // NVM full duplex default
   input  wire        nvm_force_speed_en_i,       // NVM force speed default
   input  wire        wake_mgmt_enable_i, // NVM wake management option
   input  wire        speed_bypass_i,     // Ext control speed bypass
   input  wire        phy_link_i,         // PHY link indication (async)
   input  wire        phy_duplex_ind_i,   // PHY duplex indication (async)
   input  wire [1:0]  phy_speed_i,        // PHY resolved speed
   input  wire [1:0]  det_speed_i,        // MAC auto-detected speed
   input  wire        aux_power_present_i,// Aux power pin (async)
   input  wire        an_done_i,          // Negotiation result pulse
   input  wire        an_rx_pause_i,      // Negotiated rx pause
   input  wire        an_tx_pause_i,      // Negotiated tx pause
   input  wire        master_req_i,       // Datapath wants a master req
   input  wire        master_done_i,      // One outstanding req done
   output wire        master_req_o,       // Master request granted
   output wire        bus_master_idle_status_o, // No reqs while blocked
   output reg         mac_full_duplex_o,  // Effective MAC duplex
   output reg  [1:0]  mac_speed_o,        // Effective MAC speed
   output wire        mac_link_up_o,      // Link recognised by MAC
   output wire        mac_data_en_o,      // Rx/tx data permitted
   output wire        cold_wake_advert_o, // Cold wake capability
   output wire        rx_pause_en_o,      // Act on pause frames
   output wire        tx_pause_en_o,      // Send XON/XOFF
   output wire        vlan_insert_en_o,   // Insert 802.1Q on flagged tx
   output wire        vlan_strip_en_o,    // Strip 802.1Q on rx
   output wire        mac_reset_o,        // MAC soft reset in progress
   output wire        phy_core_reset_o    // Internal PHY reset
);
   localparam integer MRST_CNT_I = `EDC_MRST_CYCLES;
   localparam [4:0]   MRST_CNT   = MRST_CNT_I[4:0];

   reg        full_duplex_sel_q;
   reg        bus_master_block_q;
   reg        auto_speed_detect_en_q;
   reg        link_up_permit_q;
   reg [1:0]  speed_sel_q;
   reg        force_speed_en_q;
   reg        force_duplex_en_q;
   reg        cold_wake_advert_en_q;
   reg        rx_pause_en_q;
   reg        tx_pause_en_q;
   reg        vlan_tag_mode_en_q;
   reg        phy_core_reset_q;
   reg        mrst_busy_q;
   reg [4:0]  mrst_cnt_q;
   reg [7:0]  outstanding_q;
   reg        link_d1_q;
   reg        sampled_dpx_q;
   wire       link_s;
   wire       dpx_s;
   wire       aux_s;
   wire       sel_ctrl;
   wire       sel_aux;
   wire       wr_ctrl;
   wire       grant;
   wire [31:0] ctrl_word;

   edc_sync3 u_sync_link (
      .clk_i   (clk_i),
      .arst_n_i(arst_n_i),
      .d_i     (phy_link_i),
      .q_o     (link_s)
   );
   edc_sync3 u_sync_dpx (
      .clk_i   (clk_i),
      .arst_n_i(arst_n_i),
      .d_i     (phy_duplex_ind_i),
      .q_o     (dpx_s)
   );
   edc_sync3 u_sync_aux (
      .clk_i   (clk_i),
      .arst_n_i(arst_n_i),
      .d_i     (aux_power_present_i),
      .q_o     (aux_s)
   );

   function is_ctrl;
      input [19:0] a;
      begin
         is_ctrl = (a == `EDC_OFF_CTRL) || (a == `EDC_OFF_CTRL_ALIAS);
      end
   endfunction

   assign sel_ctrl = is_ctrl(reg_addr_i); // RQ1
   assign sel_aux  = (reg_addr_i == `EDC_OFF_AUX);
   assign wr_ctrl  = reg_wr_i & sel_ctrl;

   // Control bits; MAC reset restores all but the PHY reset bit
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         full_duplex_sel_q      <= 1'b1;
         bus_master_block_q     <= 1'b0;
         auto_speed_detect_en_q <= 1'b0;
         link_up_permit_q       <= 1'b0;
         speed_sel_q            <= `EDC_SPD_RESET; // RQ8
         force_speed_en_q       <= 1'b0;
         force_duplex_en_q      <= 1'b0;
         cold_wake_advert_en_q  <= 1'b1;
         rx_pause_en_q          <= 1'b0;
         tx_pause_en_q          <= 1'b0;
         vlan_tag_mode_en_q     <= 1'b0;
         phy_core_reset_q       <= 1'b0;
      end else if (nvm_valid_i || (mrst_busy_q &&
                   mrst_cnt_q == MRST_CNT)) begin
         full_duplex_sel_q      <= nvm_fd_i; // RQ23
         bus_master_block_q     <= 1'b0;
         auto_speed_detect_en_q <= 1'b0;
         link_up_permit_q       <= wake_mgmt_enable_i; // RQ7
         speed_sel_q            <= `EDC_SPD_RESET;
         force_speed_en_q       <= nvm_force_speed_en_i; // RQ23
         force_duplex_en_q      <= 1'b0;
         cold_wake_advert_en_q  <= 1'b1;
         rx_pause_en_q          <= 1'b0;
         tx_pause_en_q          <= 1'b0;
         vlan_tag_mode_en_q     <= 1'b0;
      end else if (wr_ctrl) begin
         full_duplex_sel_q      <= reg_wdata_i[`EDC_BIT_FD]; // RQ2
         bus_master_block_q     <= reg_wdata_i[`EDC_BIT_BMB];
         auto_speed_detect_en_q <= reg_wdata_i[`EDC_BIT_AUTO_SPEED_DETECT_EN];
         link_up_permit_q       <= reg_wdata_i[`EDC_BIT_SLU];
         speed_sel_q <= reg_wdata_i[`EDC_BIT_SPD_HI:`EDC_BIT_SPD_LO];
         force_speed_en_q       <= reg_wdata_i[`EDC_BIT_FORCE_SPEED_EN];
         force_duplex_en_q      <= reg_wdata_i[`EDC_BIT_FRCDPX];
         cold_wake_advert_en_q  <= reg_wdata_i[`EDC_BIT_ADV];
         rx_pause_en_q          <= reg_wdata_i[`EDC_BIT_RXP];
         tx_pause_en_q          <= reg_wdata_i[`EDC_BIT_TXP];
         vlan_tag_mode_en_q     <= reg_wdata_i[`EDC_BIT_VLAN];
         phy_core_reset_q       <= reg_wdata_i[`EDC_BIT_PHYRST]; // RQ20
      end else if (an_done_i) begin
         rx_pause_en_q <= an_rx_pause_i; // RQ16
         tx_pause_en_q <= an_tx_pause_i; // RQ17
      end
   end

   // MAC soft reset sequence; pkt_buffer_alloc lives elsewhere
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mrst_busy_q <= 1'b0;
         mrst_cnt_q  <= 5'h00;
      end else if (mrst_busy_q) begin
         if (mrst_cnt_q == MRST_CNT) begin
            mrst_busy_q <= 1'b0; // RQ24
            mrst_cnt_q  <= 5'h00;
         end else begin
            mrst_cnt_q <= mrst_cnt_q + 5'h01;
         end
      end else if (wr_ctrl && reg_wdata_i[`EDC_BIT_MRST]) begin
         mrst_busy_q <= 1'b1; // RQ15
         mrst_cnt_q  <= 5'h01;
      end
   end
   assign mac_reset_o = mrst_busy_q; // RQ22

   // Master request gating and outstanding count
   assign grant = master_req_i & ~bus_master_block_q & ~mrst_busy_q; // RQ3
   assign master_req_o = grant;
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         outstanding_q <= 8'h00;
      end else if (mrst_busy_q) begin
         outstanding_q <= 8'h00;
      end else if (grant && !master_done_i) begin
         outstanding_q <= outstanding_q + 8'h01;
      end else if (!grant && master_done_i && outstanding_q != 8'h00) begin
         outstanding_q <= outstanding_q - 8'h01;
      end
   end
   assign bus_master_idle_status_o =
      ~bus_master_block_q | (outstanding_q == 8'h00); // RQ3

   // Duplex sampled on rising link edge
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link_d1_q     <= 1'b0;
         sampled_dpx_q <= 1'b0;
      end else begin
         link_d1_q <= link_s;
         if (link_s && !link_d1_q) begin
            sampled_dpx_q <= dpx_s; // RQ12
         end
      end
   end

   // Effective MAC speed and duplex
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mac_full_duplex_o <= 1'b0;
         mac_speed_o       <= `EDC_SPD_RESET;
      end else begin
         if (force_duplex_en_q) begin
            mac_full_duplex_o <= full_duplex_sel_q; // RQ12
         end else begin
            mac_full_duplex_o <= sampled_dpx_q;
         end
         if (speed_bypass_i) begin
            mac_speed_o <= phy_speed_i; // RQ10
         end else if (auto_speed_detect_en_q) begin
            mac_speed_o <= det_speed_i; // RQ5 RQ9
         end else if (force_speed_en_q) begin
            mac_speed_o <= speed_sel_q; // RQ10
         end else begin
            mac_speed_o <= phy_speed_i;
         end
      end
   end

   assign mac_link_up_o      = link_s & link_up_permit_q; // RQ6
   assign mac_data_en_o      = mac_link_up_o & ~mrst_busy_q; // RQ6
   assign cold_wake_advert_o = cold_wake_advert_en_q & aux_s; // RQ13
   assign rx_pause_en_o      = rx_pause_en_q;
   assign tx_pause_en_o      = tx_pause_en_q;
   assign vlan_insert_en_o   = vlan_tag_mode_en_q; // RQ18
   assign vlan_strip_en_o    = vlan_tag_mode_en_q; // RQ19
   assign phy_core_reset_o   = phy_core_reset_q;

   assign ctrl_word = {phy_core_reset_q, vlan_tag_mode_en_q, 1'b0,
                       tx_pause_en_q, rx_pause_en_q, mrst_busy_q,
                       5'h00, cold_wake_advert_en_q, 7'h00,
                       force_duplex_en_q, force_speed_en_q, 1'b0,
                       speed_sel_q, 1'b0, link_up_permit_q,
                       auto_speed_detect_en_q, 1'b0, 1'b1,
                       bus_master_block_q, 1'b0, full_duplex_sel_q};

   // Read data one cycle after the strobe, zero otherwise
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i && sel_ctrl) begin
         reg_rdata_o <= ctrl_word; // RQ1
      end else if (reg_rd_i && sel_aux) begin
         reg_rdata_o <= {26'h0, mac_link_up_o, mac_full_duplex_o,
                         mac_speed_o, mrst_busy_q,
                         bus_master_idle_status_o};
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end
endmodule

// >>> sim/edc_ctrl_props.sv
// Checker for the device control bank, port level only.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ps
module edc_ctrl_props (
   input wire        clk_i,               // Clock
   input wire        arst_n_i,            // Reset
   input wire [19:0] reg_addr_i,          // Addr
   input wire [31:0] reg_wdata_i,         // Wdata
   input wire        reg_wr_i,            // Write
   input wire        reg_rd_i,            // Read
   input wire [31:0] reg_rdata_o,         // Rdata
   input wire        speed_bypass_i,      // Bypass
   input wire [1:0]  phy_speed_i,         // PHY speed
   input wire        phy_link_i,          // PHY link
   input wire        aux_power_present_i, // Aux
   input wire        master_req_i,        // Req in
   input wire        master_req_o,        // Grant
   input wire [1:0]  mac_speed_o,         // Speed
   input wire        mac_link_up_o,       // Link
   input wire        mac_data_en_o,       // Data en
   input wire        cold_wake_advert_o,  // Wake
   input wire        mac_reset_o          // Soft reset
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   wire ctl_a = reg_addr_i == 20'h0 || reg_addr_i == 20'h4;
   sequence s_rst_hold;
      mac_reset_o[*8] ##1 mac_reset_o ##1 mac_reset_o ##1 !mac_reset_o;
   endsequence
   property p_grant; master_req_o |-> master_req_i && !mac_reset_o;
   endproperty
   a_grant: assert property (p_grant)
      else $error("grant without cause");
   property p_data; mac_data_en_o |-> mac_link_up_o && !mac_reset_o;
   endproperty
   a_data: assert property (p_data)
      else $error("data enabled without link");
   property p_link_low; !phy_link_i[*8] |-> !mac_link_up_o; endproperty
   a_link_low: assert property (p_link_low)
      else $error("link up while PHY link low");
   property p_wake; !aux_power_present_i[*8] |-> !cold_wake_advert_o;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake advertised without aux power");
   property p_rst_go;
      reg_wr_i && ctl_a && reg_wdata_i[26] && !mac_reset_o |=> mac_reset_o;
   endproperty
   a_rst_go: assert property (p_rst_go)
      else $error("soft reset not started");
   property p_rst_len; $rose(mac_reset_o) |-> s_rst_hold; endproperty
   a_rst_len: assert property (p_rst_len)
      else $error("soft reset length wrong");
   property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read cycle");
   property p_rd_rst;
      reg_rd_i && ctl_a && !mac_reset_o |=> !reg_rdata_o[26];
   endproperty
   a_rd_rst: assert property (p_rd_rst)
      else $error("reset bit reads one when idle");
   property p_byp;
      speed_bypass_i && !mac_reset_o ##1
      (speed_bypass_i && $stable(phy_speed_i) && !mac_reset_o)
      |-> mac_speed_o == phy_speed_i;
   endproperty
   a_byp: assert property (p_byp)
      else $error("bypass speed not followed");
endmodule
bind edc_ctrl edc_ctrl_props u_props (.clk_i, .arst_n_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .speed_bypass_i,
   .phy_speed_i, .phy_link_i, .aux_power_present_i, .master_req_i,
   .master_req_o, .mac_speed_o, .mac_link_up_o, .mac_data_en_o,
   .cold_wake_advert_o, .mac_reset_o);

// >>> sim/edc_phy_model.sv
// PHY and bus completion model at the far side of the bank.
// Assumes grants are one request per cycle.
`timescale 1ns/1ps
module edc_phy_model (
   input  wire clk_i,      // Clock
   input  wire arst_n_i,   // Reset
   input  wire link_cmd_i, // Wanted link
   input  wire dpx_cmd_i,  // Wanted duplex
   input  wire grant_i,    // Granted request
   output reg  link_o,     // PHY link
   output reg  dpx_o,      // PHY duplex
   output reg  done_o      // Request done
);
   reg  [7:0] n_q;
   wire       fin = n_q != 8'h0 && !done_o;
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link_o <= 1'b0;
         dpx_o  <= 1'b0;
         n_q    <= 8'h0;
         done_o <= 1'b0;
      end else begin
         link_o <= link_cmd_i;
         dpx_o  <= dpx_cmd_i;
         done_o <= fin;
         n_q    <= n_q + {7'h0, grant_i} - {7'h0, fin};
      end
   end
endmodule

// >>> sim/ethernet_device_control_tb_top.sv
// Testbench for the device control bank.
// Assumes edc_ctrl and its checker are compiled before it.
`timescale 1ns/1ps
module ethernet_device_control_tb_top;
   logic clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic nvm_valid_i = 0, nvm_fd_i = 1, nvm_force_speed_en_i = 0;
   logic wake_mgmt_enable_i = 0, speed_bypass_i = 0, an_done_i = 0;
   logic aux_power_present_i = 0, an_rx_pause_i = 0, an_tx_pause_i = 0;
   logic master_req_i = 0, lnk = 0, dpx = 1;
   logic [19:0] reg_addr_i = 0;
   logic [31:0] reg_wdata_i = 0, rd;
   logic [1:0]  phy_speed_i = 2'h2, det_speed_i = 2'h0;
   wire [31:0] reg_rdata_o;
   wire [1:0]  mac_speed_o;
   wire phy_link_i, phy_duplex_ind_i, master_done_i, master_req_o;
   wire bus_master_idle_status_o, mac_full_duplex_o, mac_link_up_o;
   wire mac_data_en_o, cold_wake_advert_o, rx_pause_en_o, tx_pause_en_o;
   wire vlan_insert_en_o, vlan_strip_en_o, mac_reset_o, phy_core_reset_o;
   int n_mismatch = 0, tests_run = 0;
   edc_ctrl dut (.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .nvm_valid_i, .nvm_fd_i, .nvm_force_speed_en_i,
      .wake_mgmt_enable_i, .speed_bypass_i, .phy_link_i, .phy_duplex_ind_i,
      .phy_speed_i, .det_speed_i, .aux_power_present_i, .an_done_i,
      .an_rx_pause_i, .an_tx_pause_i, .master_req_i, .master_done_i,
      .master_req_o, .bus_master_idle_status_o, .mac_full_duplex_o,
      .mac_speed_o, .mac_link_up_o, .mac_data_en_o, .cold_wake_advert_o,
      .rx_pause_en_o, .tx_pause_en_o, .vlan_insert_en_o, .vlan_strip_en_o,
      .mac_reset_o, .phy_core_reset_o);
   edc_phy_model phy (.clk_i(clk_i), .arst_n_i(arst_n_i), .link_cmd_i(lnk),
      .dpx_cmd_i(dpx), .grant_i(master_req_o), .link_o(phy_link_i),
      .dpx_o(phy_duplex_ind_i), .done_o(master_done_i));
   initial forever #50 clk_i = ~clk_i;
   task summarize;
      $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // Level to wait for: 0 link up, 1 wake advert, else master idle
   function automatic logic lvl(input int k);
      case (k)
         0: return mac_link_up_o;
         1: return cold_wake_advert_o;
         default: return bus_master_idle_status_o;
      endcase
   endfunction
   task automatic wfor(input int k);
      for (int i = 0; i < 20 && lvl(k) !== 1'b1; i++) @(negedge clk_i);
      if (lvl(k) !== 1'b1) begin
         n_mismatch++;
         summarize();
      end
   endtask
   task wr(input logic [19:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task rd_t(input logic [19:0] a);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      rd = reg_rdata_o;
   endtask
   task t_reset;
      rd_t(20'h0); chk("ctrl", rd, 32'h00100209);
      rd_t(20'h4); chk("alias", rd, 32'h00100209);
      chk("speed", mac_speed_o, 2'h2);
      rd_t(20'h10); chk("unmapped", rd, 32'h0);
      $display("test reset done");
   endtask
   task t_ctrl;
      wr(20'h4, 32'h58101949);
      phy_speed_i <= 2'h1; w(2);
      rd_t(20'h0); chk("ctrl", rd, 32'h58101949);
      chk("rxp", rx_pause_en_o, 1'b1);
      chk("txp", tx_pause_en_o, 1'b1);
      chk("vins", vlan_insert_en_o, 1'b1);
      chk("vstrip", vlan_strip_en_o, 1'b1);
      chk("speed", mac_speed_o, 2'h1);
      chk("dpx", mac_full_duplex_o, 1'b1);
      wr(20'h0, 32'hd8101948); w(2);
      chk("dpx", mac_full_duplex_o, 1'b0);
      chk("phyrst", phy_core_reset_o, 1'b1);
      wr(20'h0, 32'h00100208);
      an_rx_pause_i <= 1'b1;
      an_done_i <= 1'b1;
      @(posedge clk_i) an_done_i <= 1'b0;
      w(1); chk("anrx", rx_pause_en_o, 1'b1);
      chk("antx", tx_pause_en_o, 1'b0);
      $display("test ctrl done");
   endtask
   task t_speed;
      for (int i = 0; i < 3; i++) begin
         wr(20'h0, 32'h00100808 | (i << 8));
         phy_speed_i <= i[1:0]; w(2);
         chk("fspd", mac_speed_o, i[1:0]);
      end
      wr(20'h0, 32'h00100828);
      det_speed_i <= 2'h2; w(2);
      chk("auto", mac_speed_o, 2'h2);
      @(posedge clk_i);
      speed_bypass_i <= 1'b1;
      phy_speed_i <= 2'h1; w(3);
      chk("bypass", mac_speed_o, 2'h1);
      @(posedge clk_i) speed_bypass_i <= 1'b0;
      $display("test speed done");
   endtask
   task t_link;
      wr(20'h0, 32'h00100248); lnk <= 1'b1; wfor(0);
      chk("data", mac_data_en_o, 1'b1);
      wr(20'h0, 32'h00100208); w(1);
      chk("link", mac_link_up_o, 1'b0);
      wr(20'h0, 32'h00100249); lnk <= 1'b0; dpx <= 1'b0; w(8);
      @(posedge clk_i) lnk <= 1'b1;
      wfor(0); w(2);
      chk("sampled dpx", mac_full_duplex_o, 1'b0);
      $display("test link done");
   endtask
   task t_wake;
      @(posedge clk_i) aux_power_present_i <= 1'b1;
      wfor(1);
      wr(20'h0, 32'h00000208); w(1);
      chk("wake", cold_wake_advert_o, 1'b0);
      wr(20'h0, 32'h00100208); aux_power_present_i <= 1'b0;
      $display("test wake done");
   endtask
   task t_master;
      master_req_i <= 1'b1; w(1);
      chk("grant", master_req_o, 1'b1);
      wr(20'h0, 32'h0010020c); w(1);
      chk("blocked", master_req_o, 1'b0);
      chk("idle", bus_master_idle_status_o, 1'b0);
      @(posedge clk_i) master_req_i <= 1'b0;
      wfor(2);
      $display("test master done");
   endtask
   task t_mrst;
      wr(20'h0, 32'h04101249); w(1);
      chk("busy", mac_reset_o, 1'b1);
      w(12);
      rd_t(20'h0); chk("after", rd, 32'h00100209);
      chk("busy", mac_reset_o, 1'b0);
      @(posedge clk_i);
      wake_mgmt_enable_i <= 1'b1;
      nvm_force_speed_en_i <= 1'b1;
      nvm_valid_i <= 1'b1;
      @(posedge clk_i) nvm_valid_i <= 1'b0;
      rd_t(20'h0); chk("nvm", rd, 32'h00100a49);
      $display("test mrst done");
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reset;
      t_ctrl;
      t_speed;
      t_link;
      t_wake;
      t_master;
      t_mrst;
      summarize;
   end
endmodule
